/* File: rtl/apm_pkg.sv */
// Shared constants for the power-mode command block.
// Assumes a 10 MHz mclk and the task-file register port of the drive.
package apm_pkg;
  // Task-file offsets
  localparam logic [9:0] OFS_ERR_FEAT = 10'h1F1;
  localparam logic [9:0] OFS_COUNT = 10'h1F2;
  localparam logic [9:0] OFS_SECTOR = 10'h1F3;
  localparam logic [9:0] OFS_CYL_LO = 10'h1F4;
  localparam logic [9:0] OFS_CYL_HI = 10'h1F5;
  localparam logic [9:0] OFS_DRV_HEAD = 10'h1F6;
  localparam logic [9:0] OFS_STAT_CMD = 10'h1F7;
  // Command codes
  localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
  localparam logic [7:0] CMD_IDLE_IMM_B = 8'hE1;
  localparam logic [7:0] CMD_STBY_A = 8'h96;
  localparam logic [7:0] CMD_STBY_B = 8'hE2;
  localparam logic [7:0] CMD_STBY_IMM_A = 8'h94;
  localparam logic [7:0] CMD_STBY_IMM_B = 8'hE0;
  // Status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_ERR = 0;
  // Drive-select bit position
  localparam int DH_DRV = 4;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h01;
  // Timeout table boundaries
  localparam logic [7:0] TMO_SEC_MAX = 8'hF0;
  localparam logic [7:0] TMO_HALF_MAX = 8'hFB;
  localparam logic [7:0] TMO_21M = 8'hFC;
  localparam logic [7:0] TMO_8H = 8'hFD;
  // Timeout units in seconds
  localparam int SEC_STEP = 5;
  localparam int SEC_HALF_HOUR = 1800;
  localparam int SEC_21M = 1260;
  localparam int SEC_8H = 28800;
  localparam int SEC_21M15 = 1275;
  // Clock rate and one-second tick
  localparam int CLK_HZ = 10000000;
  localparam int SEC_CYCLES = CLK_HZ;
  // Spindle ramp time in milliseconds
  localparam int SPIN_MS = 100;
  localparam int SPIN_CYCLES = SPIN_MS * (CLK_HZ / 1000);
endpackage

/* File: rtl/apm_spindle.sv */
// Spindle motor model: ramps up or down over a programmable time.
// Assumes run requests come from logic on the same mclk.
`timescale 1ns/1ps
module apm_spindle #(
  parameter int RAMP_CYCLES = apm_pkg::SPIN_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic run_req,
  // Status
  output logic spinning,
  output logic stopped
);
  initial begin
    if (RAMP_CYCLES < 1) $error("RAMP_CYCLES must be at least one");
  end

  // All state in one struct
  typedef struct packed {
    logic at_speed;
    logic at_rest;
    logic [31:0] cnt;
  } apm_spin_t;
  apm_spin_t st_ff, nxt_st;

  // Ramp towards the requested state, then settle
  always_comb begin
    nxt_st = st_ff;
    if (run_req && !st_ff.at_speed) begin
      nxt_st.at_rest = 1'b0;
      nxt_st.cnt = st_ff.cnt + 32'h1;
      if (st_ff.cnt >= 32'(RAMP_CYCLES - 1)) begin
        nxt_st.at_speed = 1'b1;
        nxt_st.cnt = 32'h0;
      end
    end else if (!run_req && !st_ff.at_rest) begin
      nxt_st.at_speed = 1'b0;
      nxt_st.cnt = st_ff.cnt + 32'h1;
      if (st_ff.cnt >= 32'(RAMP_CYCLES - 1)) begin
        nxt_st.at_rest = 1'b1;
        nxt_st.cnt = 32'h0;
      end
    end else begin
      nxt_st.cnt = 32'h0;
    end
  end

  // Motor comes up spinning after reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{at_speed: 1'b1, at_rest: 1'b0, cnt: 32'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign spinning = st_ff.at_speed;
  assign stopped = st_ff.at_rest;
endmodule

/* File: rtl/apm_power_cmd.sv */
// Power-mode command interpreter behind the task-file registers.
// Assumes the register strobes are already synchronous to mclk.
`timescale 1ns/1ps
// Functional notes
// - Codes 95h or E1h mean idle now
// - Idle now: busy, idle, clear busy, interrupt
// - Idle now never touches power-down timer settings
// - Codes 96h or E2h mean timed standby
// - Standby: busy, standby, clear busy, interrupt
// - Standby may finish before spindle stops
// - Already stopped spindle skips spin-down
// - Nonzero count arms timer, runs in idle
// - Timer expiry moves idle into standby
// - Zero count disables automatic power-down
// - Spindle stays stopped in standby
// - Seek command in standby spins up first
// - Codes 94h or E0h mean standby now
// - Standby now leaves timer settings untouched
// - Count value selects timeout per table
// - Any command restarts timer after completion
module apm_power_cmd #(
  parameter int SEC_CYCLES = apm_pkg::SEC_CYCLES,
  parameter int SPIN_CYCLES = apm_pkg::SPIN_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Task-file register port
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Host interrupt, level until status read
  output logic host_irq,
  // Other drive commands needing the spindle
  input wire logic seek_cmd,
  output logic seek_go,
  // Power state views
  output logic in_standby,
  output logic motor_run
);
  // A zero second length would wrap the tick limit to all ones and stall the timer
  initial begin
    if (SEC_CYCLES < 1) $error("SEC_CYCLES must be at least one");
  end

  // Mode states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_BUSY = 4'h2,
    S_STBY = 4'h4,
    S_SPINUP = 4'h8
  } apm_state_t;

  // Command kinds
  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_IDLE = 2'h1,
    K_STBY = 2'h2,
    K_STBY_IMM = 2'h3
  } apm_kind_t;

  // All block state
  typedef struct packed {
    apm_state_t state;
    apm_kind_t kind;
    logic [7:0] feat;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drv_head;
    logic [7:0] rdata;
    logic irq;
    logic apd_en;
    logic [7:0] apd_code;
    logic [15:0] apd_secs;
    logic [31:0] tick;
    logic seek_go;
  } apm_reg_t;
  apm_reg_t st_ff, nxt_st;

  logic spinning;
  logic stopped;
  logic want_run;

  // Decode a command code into its kind
  function automatic apm_kind_t decode_cmd(input logic [7:0] code);
    case (code)
      apm_pkg::CMD_IDLE_IMM_A, apm_pkg::CMD_IDLE_IMM_B: decode_cmd = K_IDLE;
      apm_pkg::CMD_STBY_A, apm_pkg::CMD_STBY_B: decode_cmd = K_STBY;
      apm_pkg::CMD_STBY_IMM_A, apm_pkg::CMD_STBY_IMM_B: decode_cmd = K_STBY_IMM;
      default: decode_cmd = K_NONE;
    endcase
  endfunction

  // Timeout in seconds for a count code
  // Every code fits 16 bits; the 8 h setting is the longest span
  function automatic logic [15:0] timeout_secs(input logic [7:0] code);
    if (code <= apm_pkg::TMO_SEC_MAX) begin
      timeout_secs = 16'(code * apm_pkg::SEC_STEP);
    end else if (code <= apm_pkg::TMO_HALF_MAX) begin
      timeout_secs = 16'((code - apm_pkg::TMO_SEC_MAX) * apm_pkg::SEC_HALF_HOUR);
    end else if (code == apm_pkg::TMO_21M) begin
      timeout_secs = 16'(apm_pkg::SEC_21M);
    end else if (code == apm_pkg::TMO_8H) begin
      timeout_secs = 16'(apm_pkg::SEC_8H);
    end else begin
      timeout_secs = 16'(apm_pkg::SEC_21M15);
    end
  endfunction

  // Spindle follows the power mode
  // Ramp length is a parameter so simulation can shorten it
  apm_spindle #(
    .RAMP_CYCLES(SPIN_CYCLES)
  ) u_spindle (
    .mclk(mclk),
    .reset_n(reset_n),
    .run_req(want_run),
    .spinning(spinning),
    .stopped(stopped)
  );

  // Motor runs outside standby; busy before standby keeps it off
  // Standby kinds drop the request at once, so busy can clear
  // while the spindle is still coasting down
  assign want_run = (st_ff.state == S_IDLE) || (st_ff.state == S_SPINUP) ||
    ((st_ff.state == S_BUSY) && (st_ff.kind == K_IDLE));

  // Register, command and timer logic
  always_comb begin
    logic wr_cmd;
    logic [7:0] status;
    wr_cmd = 1'b0;
    status = 8'h00;
    nxt_st = st_ff;
    nxt_st.seek_go = 1'b0;
    nxt_st.rdata = st_ff.rdata;

    // Parameter writes; host loads these before the opcode
    // Feature byte is held for the host; no power command uses it
    if (reg_wr) begin
      case (reg_addr)
        apm_pkg::OFS_ERR_FEAT: nxt_st.feat = reg_wdata;
        apm_pkg::OFS_COUNT: nxt_st.count = reg_wdata;
        apm_pkg::OFS_SECTOR: nxt_st.sector = reg_wdata;
        apm_pkg::OFS_CYL_LO: nxt_st.cyl_lo = reg_wdata;
        apm_pkg::OFS_CYL_HI: nxt_st.cyl_hi = reg_wdata;
        apm_pkg::OFS_DRV_HEAD: nxt_st.drv_head = reg_wdata;
        apm_pkg::OFS_STAT_CMD: wr_cmd = 1'b1;
        default: ;
      endcase
    end

    // Status byte
    status[apm_pkg::ST_BSY] = (st_ff.state == S_BUSY) || (st_ff.state == S_SPINUP);
    status[apm_pkg::ST_DRDY] = !status[apm_pkg::ST_BSY];
    // Error bit stays low: none of these commands can abort
    status[apm_pkg::ST_ERR] = 1'b0;

    // Read data; status read acknowledges the interrupt
    if (reg_rd) begin
      case (reg_addr)
        apm_pkg::OFS_ERR_FEAT: nxt_st.rdata = apm_pkg::RST_REG;
        apm_pkg::OFS_COUNT: nxt_st.rdata = st_ff.count;
        apm_pkg::OFS_SECTOR: nxt_st.rdata = st_ff.sector;
        apm_pkg::OFS_CYL_LO: nxt_st.rdata = st_ff.cyl_lo;
        apm_pkg::OFS_CYL_HI: nxt_st.rdata = st_ff.cyl_hi;
        apm_pkg::OFS_DRV_HEAD: nxt_st.rdata = st_ff.drv_head;
        apm_pkg::OFS_STAT_CMD: begin
          nxt_st.rdata = status;
          nxt_st.irq = 1'b0;
        end
        default: nxt_st.rdata = apm_pkg::RST_REG;
      endcase
    end

    // Power-down countdown, only while idle and quiet
    // Reloading on every other path means a stray command never
    // leaves a half-spent count behind
    if (st_ff.state == S_IDLE && st_ff.apd_en && !wr_cmd && !seek_cmd) begin
      if (st_ff.tick >= 32'(SEC_CYCLES - 1)) begin
        nxt_st.tick = 32'h0;
        nxt_st.apd_secs = st_ff.apd_secs - 16'h1;
      end else begin
        nxt_st.tick = st_ff.tick + 32'h1;
      end
    end else begin
      // Any activity reloads the countdown
      nxt_st.tick = 32'h0;
      nxt_st.apd_secs = timeout_secs(st_ff.apd_code);
    end

    // Mode sequencing
    case (st_ff.state)
      S_IDLE, S_STBY: begin
        // A decoded opcode beats seek, seek beats expiry; foreign codes do not
        if (wr_cmd && decode_cmd(reg_wdata) != K_NONE) begin
          nxt_st.kind = decode_cmd(reg_wdata);
          nxt_st.state = S_BUSY;
          if (decode_cmd(reg_wdata) == K_STBY) begin
            nxt_st.apd_en = (st_ff.count != 8'h00);
            nxt_st.apd_code = st_ff.count;
          end
        end else if (seek_cmd && st_ff.state == S_STBY) begin
          nxt_st.state = S_SPINUP;
        end else if (seek_cmd) begin
          nxt_st.seek_go = 1'b1;
        end else if (st_ff.state == S_IDLE && st_ff.apd_en &&
                     st_ff.apd_secs == 16'h0) begin
          nxt_st.state = S_STBY;
        end
      end
      S_BUSY: begin
        // Completion does not wait for the spindle to stop
        nxt_st.state = (st_ff.kind == K_IDLE) ? S_IDLE : S_STBY;
        // Set here wins over a status read in the same cycle
        nxt_st.irq = 1'b1;
      end
      S_SPINUP: begin
        // Busy stays up until the motor is at speed
        if (spinning) begin
          nxt_st.state = S_IDLE;
          nxt_st.seek_go = 1'b1;
        end
      end
      default: nxt_st.state = S_IDLE;
    endcase
  end

  // Single register stage for all state
  // Reset leaves this block idle with the spindle model turning
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{state: S_IDLE, kind: K_NONE, feat: apm_pkg::RST_REG,
                 count: apm_pkg::RST_COUNT, sector: apm_pkg::RST_COUNT,
                 cyl_lo: apm_pkg::RST_REG, cyl_hi: apm_pkg::RST_REG,
                 drv_head: apm_pkg::RST_REG, rdata: apm_pkg::RST_REG,
                 irq: 1'b0, apd_en: 1'b0, apd_code: apm_pkg::RST_REG,
                 apd_secs: 16'h0, tick: 32'h0, seek_go: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign host_irq = st_ff.irq;
  assign seek_go = st_ff.seek_go;
  assign in_standby = (st_ff.state == S_STBY);
  assign motor_run = spinning;

  // Sequencer checks; all sample on the rising edge
  // Idle-now clears busy next cycle with interrupt
  idle_done_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY && st_ff.kind == K_IDLE) |=> (st_ff.state == S_IDLE && host_irq))
    else $error("idle command did not complete");

  // Standby commands land in standby with interrupt
  stby_done_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY && st_ff.kind != K_IDLE) |=> (in_standby && host_irq))
    else $error("standby command did not complete");

  // Idle-now leaves timer settings alone
  idle_timer_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY && st_ff.kind == K_IDLE) |->
      ($stable(st_ff.apd_en) && $stable(st_ff.apd_code)))
    else $error("idle command changed timer");

  // Standby-now leaves timer settings alone
  imm_timer_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY && st_ff.kind == K_STBY_IMM) |->
      ($stable(st_ff.apd_en) && $stable(st_ff.apd_code)))
    else $error("standby now changed timer");

  // Standby count arms or disarms timer
  stby_arm_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY && st_ff.kind == K_STBY) |-> (st_ff.apd_en == (st_ff.apd_code != 8'h00)))
    else $error("standby count did not set timer");

  // Expiry in idle leads to standby
  apd_fire_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_IDLE && st_ff.apd_en && st_ff.apd_secs == 16'h0 && !reg_wr && !seek_cmd)
    |=> in_standby)
    else $error("timer expiry ignored");

  // Motor never asked to run in standby
  stby_motor_a: assert property (@(posedge mclk) disable iff (!reset_n)
    in_standby |-> !want_run)
    else $error("motor requested in standby");

  // Seek in standby waits for spin-up
  seek_spin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    seek_go |-> motor_run || $past(st_ff.state) == S_IDLE)
    else $error("seek released before spin-up");

  // Busy lasts exactly one cycle for these commands
  busy_once_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY) |=> (st_ff.state != S_BUSY))
    else $error("busy held longer than one cycle");

  // Status read outside busy drops the interrupt
  irq_ack_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd && reg_addr == apm_pkg::OFS_STAT_CMD && st_ff.state != S_BUSY) |=> !host_irq)
    else $error("status read left interrupt set");

  // Timer off: idle never drops into standby alone
  apd_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_IDLE && !st_ff.apd_en) |=> !in_standby)
    else $error("standby entered with timer off");

  // Timer stays parked while in standby
  tmr_park_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_STBY) |=> (st_ff.tick == 32'h0))
    else $error("timer ran in standby");

  // Motor not at speed from the second standby cycle on
  stby_spin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (in_standby && $past(in_standby)) |-> !motor_run)
    else $error("spindle turning in standby");

  // Spindle already at rest stays at rest through a standby command
  spin_rest_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_BUSY && st_ff.kind != K_IDLE && stopped) |=> stopped)
    else $error("stopped spindle was moved");

  // Seek in idle is released on the next edge
  seek_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_IDLE && seek_cmd && !reg_wr) |=> seek_go)
    else $error("idle seek not released");

  // No seek release while the motor is still ramping
  spin_wait_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_ff.state == S_SPINUP && !spinning) |=> (st_ff.state == S_SPINUP && !seek_go))
    else $error("seek released during spin-up");

  // Read data holds until the next read
  rdata_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule

/* File: verif/apm_host_model.sv */
// Host adapter model driving the task-file register port of the drive.
// Assumes the bench calls its tasks and that mclk runs freely.
`timescale 1ns/1ps
module apm_host_model (
  // Clock
  input wire logic mclk,
  // Register port toward the drive
  output logic [9:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Quiet bus from time zero
  initial begin
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // One write strobe, raised and dropped on falling edges
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Released lines flip so stale data never looks current
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask

  // One read strobe; data is registered, so it is taken a cycle later
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

/* File: verif/ata_power_mode_commands_test.sv */
// Self-checking bench for the power-mode command interpreter.
// Assumes short second and ramp counts so timer runs stay brief.
`timescale 1ns/1ps
module ata_power_mode_commands_test;
  localparam int SEC = 4;
  localparam int SPIN = 8;
  // Clock, reset and drive-side strobes
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic seek_cmd = 1'b0;
  logic [9:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic host_irq;
  logic seek_go;
  logic in_standby;
  logic motor_run;
  // Scoreboard
  int fail_count = 0;
  int compares = 0;
  logic [7:0] rd;
  int n;
  // Command table and whether each ends in standby
  logic [7:0] codes [6] = '{apm_pkg::CMD_IDLE_IMM_A, apm_pkg::CMD_STBY_A,
    apm_pkg::CMD_STBY_B, apm_pkg::CMD_IDLE_IMM_B, apm_pkg::CMD_STBY_IMM_A,
    apm_pkg::CMD_STBY_IMM_B};
  logic [5:0] stby = 6'h36;

  always #50 mclk = ~mclk;

  apm_host_model apm_host_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  apm_power_cmd #(.SEC_CYCLES(SEC), .SPIN_CYCLES(SPIN)) apm_power_cmd_i (.mclk(mclk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_irq(host_irq),
    .seek_cmd(seek_cmd), .seek_go(seek_go), .in_standby(in_standby),
    .motor_run(motor_run));

  // Counts printed once, then the verdict
  task automatic results();
    $display("Mismatches %0d, comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare one byte, counting both outcomes
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // Spent wait bound ends the run early
  task automatic bound(input int cnt, input int lim, input string what);
    chk((cnt < lim) ? 8'h01 : 8'h00, 8'h01, what);
    if (cnt >= lim) begin
      results();
    end
  endtask

  // Parameters first, opcode last, then service the interrupt
  task automatic cmd(input logic [7:0] cnt, input logic [7:0] op);
    apm_host_model_i.wr_reg(apm_pkg::OFS_COUNT, cnt);
    apm_host_model_i.wr_reg(apm_pkg::OFS_STAT_CMD, op);
    for (n = 0; n < 40 && host_irq !== 1'b1; n++) @(negedge mclk);
    bound(n, 40, "command interrupt");
    apm_host_model_i.rd_reg(apm_pkg::OFS_STAT_CMD, rd);
    chk(rd, 8'h40, "status after command");
    chk({7'h00, host_irq}, 8'h00, "interrupt cleared by status read");
  endtask

  // Automatic standby must not come before lo cycles nor after hi
  task automatic expiry(input int lo, input int hi);
    for (n = 0; n < hi && in_standby !== 1'b1; n++) @(negedge mclk);
    bound(n, hi, "automatic standby in time");
    chk((n >= lo) ? 8'h01 : 8'h00, 8'h01, "automatic standby too early");
  endtask

  // Seek request held until granted
  task automatic seek();
    @(negedge mclk);
    seek_cmd = 1'b1;
    for (n = 0; n < 40 && seek_go !== 1'b1; n++) @(negedge mclk);
    seek_cmd = 1'b0;
    bound(n, 40, "seek granted");
    chk({7'h00, motor_run}, 8'h01, "spindle at speed when seek runs");
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    chk({6'h00, in_standby, motor_run}, 8'h01, "power state after reset");
    apm_host_model_i.rd_reg(apm_pkg::OFS_COUNT, rd);
    chk(rd, apm_pkg::RST_COUNT, "count reset value");
    apm_host_model_i.rd_reg(10'h1F0, rd);
    chk(rd, 8'h00, "unmapped read");
    apm_host_model_i.rd_reg(apm_pkg::OFS_ERR_FEAT, rd);
    chk(rd, 8'h00, "fault detail read");
    for (int i = 0; i < 3; i++) begin
      apm_host_model_i.wr_reg(apm_pkg::OFS_SECTOR + 10'(i), 8'hA5 ^ 8'(i));
      apm_host_model_i.rd_reg(apm_pkg::OFS_SECTOR + 10'(i), rd);
      chk(rd, 8'hA5 ^ 8'(i), "parameter readback");
    end
    // Foreign opcode must be ignored
    apm_host_model_i.wr_reg(apm_pkg::OFS_STAT_CMD, 8'hE8);
    repeat (10) @(negedge mclk);
    chk({7'h00, host_irq}, 8'h00, "foreign opcode ignored");
    // Every code; E2h and E0h arrive with the spindle stopped, 94h during spin-up
    for (int i = 0; i < 6; i++) begin
      cmd(8'h00, codes[i]);
      chk({7'h00, in_standby}, {7'h00, stby[i]}, "mode after command");
      if (stby[i]) begin
        repeat (SPIN + 4) @(negedge mclk);
        chk({7'h00, motor_run}, 8'h00, "spindle stopped in standby");
      end
    end
    // Zero count leaves the timer off; back to idle where it would run
    cmd(8'h00, apm_pkg::CMD_IDLE_IMM_A);
    repeat (60) @(negedge mclk);
    chk({7'h00, in_standby}, 8'h00, "no automatic standby");
    // Armed by standby, counted only once back in idle
    for (int c = 1; c <= 3; c += 2) begin
      cmd(8'(c), apm_pkg::CMD_STBY_B);
      cmd(8'h00, apm_pkg::CMD_IDLE_IMM_A);
      expiry(5 * c * SEC - 6, 5 * c * SEC + 10);
    end
    // Immediate standby keeps the armed period of 3
    cmd(8'h00, apm_pkg::CMD_STBY_IMM_B);
    cmd(8'h00, apm_pkg::CMD_IDLE_IMM_B);
    repeat (40) @(negedge mclk);
    seek();
    repeat (40) @(negedge mclk);
    chk({7'h00, in_standby}, 8'h00, "timer restarted by seek");
    expiry(14, 30);
    repeat (SPIN + 4) @(negedge mclk);
    seek();
    chk({7'h00, in_standby}, 8'h00, "seek leaves standby");
    results();
  end
endmodule
